// *** rtl/icrs_device.sv ***
// Configuration register slave end of the two-wire link.
`timescale 1ns/1ps
`include "icrs_params.svh"
module icrs_device
  import icrs_pkg::*;
(
  input  wire logic reference_clock_input, // Link-side reference clock.
  input  wire logic arst_n,                // Asynchronous reset, active low.
  icrs_link_if.dev  link,                  // Two-wire link.
  input  wire logic cfg_from_port,         // Strap: 1 wait for serial config.
  output      logic hub_attach,            // Upstream connect permitted.
  output      logic cfg_locked             // Write protection active.
);
  logic [7:0] mem [0:`ICRS_REG_DEPTH-1];
  icrs_dst_t  st_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] strap_sync_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic       rw_reg;
  logic       mack_reg;
  logic       wp_reg;
  logic       ld_busy_reg;
  logic [7:0] ld_addr_reg;
  logic       port_mode_reg;
  logic       attach_reg;
  logic       scl_s;
  logic       sda_s;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;
  logic       byte_done;
  logic       wr_strobe;
  logic [7:0] rd_byte;

  // ==========================================================================
  // Pin synchronisers and bus conditions
  // ==========================================================================
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      strap_sync_reg <= 2'h0;
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], link.scl};
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
      strap_sync_reg <= {strap_sync_reg[0], cfg_from_port};
      scl_q_reg    <= scl_sync_reg[1];
      sda_q_reg    <= sda_sync_reg[1];
    end

  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  // The sampling clock is far faster than any bus rate, so edges are exact.
  assign scl_rise  = scl_s && !scl_q_reg;
  assign scl_fall  = !scl_s && scl_q_reg;
  assign start_det = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign stop_det  = scl_s && scl_q_reg && !sda_q_reg && sda_s;
  assign byte_done = (cnt_reg == `ICRS_BYTE_BITS);
  assign wr_strobe = scl_fall && (st_reg == D_WDATA) && byte_done;
  assign rd_byte   = (ptr_reg == `ICRS_STCD_ADDR) ? {7'h00, wp_reg} : mem[ptr_reg];

  // ==========================================================================
  // Default configuration load after reset
  // ==========================================================================
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
    begin
      ld_busy_reg   <= 1'b1;
      ld_addr_reg   <= 8'h00;
      port_mode_reg <= 1'b0;
    end
    else if (ld_busy_reg)
    begin
      ld_addr_reg <= ld_addr_reg + 8'h01;
      // The strap is taken at the end of the load, long after its synchroniser has settled.
      if (ld_addr_reg == `ICRS_REG_LAST)
      begin
        ld_busy_reg   <= 1'b0;
        port_mode_reg <= strap_sync_reg[1];
      end
    end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  always_ff @(posedge reference_clock_input)
    if (ld_busy_reg)
      mem[ld_addr_reg] <= `ICRS_DEF_FILL;
    else if (wr_strobe && !wp_reg && ptr_reg != `ICRS_STCD_ADDR)
      mem[ptr_reg] <= sh_reg;

  // Protection can only be set; nothing but the reset pin clears it.
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
      wp_reg <= 1'b0;
    else if (wr_strobe && ptr_reg == `ICRS_STCD_ADDR && sh_reg[`ICRS_WP_BIT])
      wp_reg <= 1'b1;

  // In serial mode the hub waits until the master locks the configuration.
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
      attach_reg <= 1'b0;
    else
      attach_reg <= !ld_busy_reg && (!port_mode_reg || wp_reg);

  assign hub_attach = attach_reg;
  assign cfg_locked = wp_reg;

  // ==========================================================================
  // Register pointer
  // ==========================================================================
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
      ptr_reg <= 8'h00;
    else if (scl_fall)
    begin
      if (st_reg == D_REG && byte_done)
        ptr_reg <= sh_reg;
      else if (st_reg == D_WACK)
        ptr_reg <= ptr_reg + 8'h01;
      else if (st_reg == D_RDATA && byte_done)
        ptr_reg <= ptr_reg + 8'h01;
    end

  // ==========================================================================
  // Protocol state machine
  // ==========================================================================
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
    begin
      st_reg   <= D_IDLE;
      cnt_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      tx_reg   <= 8'hff;
      rw_reg   <= 1'b0;
      mack_reg <= 1'b1;
    end
    else if (start_det)
    begin
      st_reg  <= D_ADDR;
      cnt_reg <= 4'h0;
    end
    else if (stop_det)
      st_reg <= D_IDLE;
    else if (scl_rise)
    begin
      if (st_reg == D_ADDR || st_reg == D_REG || st_reg == D_WDATA)
      begin
        sh_reg  <= {sh_reg[6:0], sda_s};
        cnt_reg <= cnt_reg + 4'h1;
      end
      else if (st_reg == D_RDATA)
        cnt_reg <= cnt_reg + 4'h1;
      else if (st_reg == D_MACK)
        mack_reg <= sda_s;
    end
    else if (scl_fall)
      case (st_reg)
        D_ADDR:
          if (byte_done)
          begin
            rw_reg <= sh_reg[0];
            if (!ld_busy_reg && sh_reg[7:1] == `ICRS_SLAVE_ADDR)
              st_reg <= D_AACK;
            else
              st_reg <= D_IGNORE;
          end
        D_AACK:
        begin
          cnt_reg <= 4'h0;
          tx_reg  <= rd_byte;
          st_reg  <= rw_reg ? D_RDATA : D_REG;
        end
        D_REG:
          if (byte_done)
            st_reg <= D_REGACK;
        D_REGACK:
        begin
          cnt_reg <= 4'h0;
          st_reg  <= D_WDATA;
        end
        D_WDATA:
          if (byte_done)
            st_reg <= D_WACK;
        D_WACK:
        begin
          cnt_reg <= 4'h0;
          st_reg  <= D_WDATA;
        end
        D_RDATA:
          if (byte_done)
            st_reg <= D_MACK;
          else
            tx_reg <= {tx_reg[6:0], 1'b1};
        D_MACK:
          if (!mack_reg)
          begin
            cnt_reg <= 4'h0;
            tx_reg  <= rd_byte;
            st_reg  <= D_RDATA;
          end
          else
            st_reg <= D_IGNORE;
        default: ;
      endcase

  // ==========================================================================
  // Data line drive
  // ==========================================================================
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe  = (st_reg == D_AACK) || (st_reg == D_REGACK) ||
                            (st_reg == D_WACK) || ((st_reg == D_RDATA) && !tx_reg[7]);
endmodule : icrs_device

// *** rtl/icrs_host.sv ***
// Serial master that writes and reads the slave's register space.
`timescale 1ns/1ps
`include "icrs_params.svh"
module icrs_host
  import icrs_pkg::*;
(
  input  wire logic       clk,          // System clock.
  input  wire logic       arst_n,       // Asynchronous reset, active low.
  icrs_link_if.host       link,         // Two-wire link.
  input  wire logic       cmd_valid,    // Transfer request.
  output      logic       cmd_ready,    // Ready for a request.
  input  wire logic       cmd_read,     // 1 read, 0 write.
  input  wire logic [7:0] cmd_reg,      // Start register address.
  input  wire logic [7:0] cmd_len,      // Number of data bytes.
  input  wire logic       cmd_stop_mid, // Stop instead of repeated Start.
  input  wire logic       wr_valid,     // Write byte available.
  input  wire logic [7:0] wr_data,      // Write byte.
  output      logic       wr_ready,     // Write byte taken.
  output      logic [7:0] rd_data,      // Read byte.
  output      logic       rd_valid,     // Read byte pulse.
  output      logic       done,         // Transfer finished pulse.
  output      logic       nack_err      // Slave refused a byte.
);
  localparam logic [7:0] QTR_LAST = 8'(`ICRS_QTR_CYC - 1);
  icrs_hst_t  st_reg;
  icrs_kind_t kind_reg;
  logic [1:0] sda_sync_reg;
  logic [7:0] div_reg;
  logic [1:0] ph_reg;
  logic [3:0] bitn_reg;
  logic [8:0] txb_reg;
  logic [8:0] rxb_reg;
  logic [7:0] left_reg;
  logic [7:0] regaddr_reg;
  logic       rd_reg;
  logic       stopmid_reg;
  logic       again_reg;
  logic       scl_oe_reg;
  logic       sda_oe_reg;
  logic       tick;
  logic [8:0] load_byte;

  // ==========================================================================
  // Pin sampling and bit timing
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      sda_sync_reg <= 2'h3;
    else
      sda_sync_reg <= {sda_sync_reg[0], link.sda};

  assign tick = (div_reg == QTR_LAST);

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      div_reg <= 8'h00;
      ph_reg  <= 2'h0;
    end
    else
    begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      if (tick && (st_reg == H_START || st_reg == H_BYTE || st_reg == H_STOP))
        ph_reg <= ph_reg + 2'h1;
    end

  always_comb
  begin
    case (kind_reg)
      K_AWR:   load_byte = {`ICRS_SLAVE_ADDR, 1'b0, 1'b1};
      K_REG:   load_byte = {regaddr_reg, 1'b1};
      K_WDAT:  load_byte = {wr_data, 1'b1};
      K_ARD:   load_byte = {`ICRS_SLAVE_ADDR, 1'b1, 1'b1};
      default: load_byte = {8'hff, left_reg == 8'h01};
    endcase
  end

  assign cmd_ready = (st_reg == H_IDLE);
  assign wr_ready  = (st_reg == H_LOAD) && (kind_reg == K_WDAT);
  assign link.host_scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;
  assign link.host_scl_oe  = scl_oe_reg;
  assign link.host_sda_oe  = sda_oe_reg;

  // ==========================================================================
  // Transfer sequencer
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      st_reg <= H_IDLE;
      kind_reg <= K_AWR;
      bitn_reg <= 4'h0;
      txb_reg <= 9'h1ff;
      rxb_reg <= 9'h000;
      left_reg <= 8'h00;
      regaddr_reg <= 8'h00;
      rd_reg <= 1'b0;
      stopmid_reg <= 1'b0;
      again_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      case (st_reg)
        H_IDLE:
          if (cmd_valid)
          begin
            st_reg <= H_START;
            kind_reg <= K_AWR;
            rd_reg <= cmd_read;
            regaddr_reg <= cmd_reg;
            left_reg <= cmd_len;
            stopmid_reg <= cmd_stop_mid;
            nack_err <= 1'b0;
          end
        H_START:
          if (tick)
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default:
              begin
                scl_oe_reg <= 1'b1;
                st_reg <= H_LOAD;
              end
            endcase
        H_LOAD:
          if (kind_reg != K_WDAT || wr_valid)
          begin
            txb_reg <= load_byte;
            bitn_reg <= 4'h0;
            st_reg <= H_BYTE;
          end
        H_BYTE:
          if (tick)
            case (ph_reg)
              2'h0: sda_oe_reg <= !txb_reg[8];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: rxb_reg <= {rxb_reg[7:0], sda_sync_reg[1]};
              default:
              begin
                scl_oe_reg <= 1'b1;
                txb_reg <= {txb_reg[7:0], 1'b1};
                bitn_reg <= bitn_reg + 4'h1;
                if (bitn_reg == `ICRS_BYTE_BITS)
                begin
                  if (kind_reg != K_RDAT && rxb_reg[0])
                  begin
                    nack_err <= 1'b1;
                    st_reg <= H_STOP;
                  end
                  else
                    case (kind_reg)
                      K_AWR:
                      begin
                        kind_reg <= K_REG;
                        st_reg <= H_LOAD;
                      end
                      K_REG:
                      begin
                        kind_reg <= rd_reg ? K_ARD : K_WDAT;
                        st_reg <= !rd_reg ? H_LOAD : (stopmid_reg ? H_STOP : H_START);
                        again_reg <= rd_reg && stopmid_reg;
                      end
                      K_ARD:
                      begin
                        kind_reg <= K_RDAT;
                        st_reg <= H_LOAD;
                      end
                      default:
                      begin
                        if (kind_reg == K_RDAT)
                        begin
                          rd_data <= rxb_reg[8:1];
                          rd_valid <= 1'b1;
                        end
                        left_reg <= left_reg - 8'h01;
                        st_reg <= (left_reg <= 8'h01) ? H_STOP : H_LOAD;
                      end
                    endcase
                end
              end
            endcase
        H_STOP:
          if (tick)
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default:
              begin
                again_reg <= 1'b0;
                st_reg <= again_reg ? H_START : H_IDLE;
                done <= !again_reg;
              end
            endcase
        default: st_reg <= H_IDLE;
      endcase
    end
endmodule : icrs_host

// *** rtl/icrs_link_if.sv ***
// Two-wire link between the serial master and the configuration slave.
`timescale 1ns/1ps
interface icrs_link_if;
  logic scl;
  logic sda;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  // Open-drain wired-AND with pull-ups: any enabled driver whose output value is 0 pulls low.
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
                output host_sda_out, output host_sda_oe);
endinterface : icrs_link_if

// *** rtl/icrs_params.svh ***
// Constants shared by both ends of the configuration register serial port.
`ifndef ICRS_PARAMS_SVH
`define ICRS_PARAMS_SVH
`define ICRS_SLAVE_ADDR 7'h08
`define ICRS_REG_DEPTH  256
`define ICRS_REG_LAST   8'hff
`define ICRS_STCD_ADDR  8'hff
`define ICRS_WP_BIT     0
`define ICRS_DEF_FILL   8'h00
`define ICRS_BYTE_BITS  4'h8
`define ICRS_CLK_KHZ    25000
`define ICRS_SCL_KHZ    400
`define ICRS_QTR_CYC    ((`ICRS_CLK_KHZ + 4 * `ICRS_SCL_KHZ - 1) / (4 * `ICRS_SCL_KHZ))
`endif

// *** rtl/icrs_pkg.sv ***
// Types shared by both ends of the configuration register serial port.
package icrs_pkg;
  typedef enum logic [3:0] {
    D_IDLE, D_ADDR, D_AACK, D_REG, D_REGACK, D_WDATA, D_WACK, D_RDATA, D_MACK, D_IGNORE
  } icrs_dst_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_LOAD, H_BYTE, H_STOP} icrs_hst_t;
  typedef enum logic [2:0] {K_AWR, K_REG, K_WDAT, K_ARD, K_RDAT} icrs_kind_t;
endpackage : icrs_pkg

// *** tb/i2c_config_register_slave_tb.sv ***
// Self-checking bench for both ends of the configuration register serial port.
`timescale 1ns/1ps
`include "icrs_params.svh"
module i2c_config_register_slave_tb
  import icrs_pkg::*;
;
  logic        clk;
  logic        reference_clock_input;
  logic        arst_n;
  logic        cfg_from_port;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_read;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_len;
  logic        cmd_stop_mid;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic        wr_ready;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        done;
  logic        nack_err;
  logic        hub_attach;
  logic        cfg_locked;
  logic [7:0]  mem [256];
  logic [7:0]  wbuf [16];
  logic [7:0]  rbuf [16];
  logic        lock;
  logic [31:0] seed;
  int          fails;
  int          total_checks;
  int          cycles;
  icrs_link_if link_a ();
  icrs_link_if link_b ();
  icrs_host icrs_host_inst (.clk, .arst_n, .link(link_a.host), .cmd_valid, .cmd_ready,
    .cmd_read, .cmd_reg, .cmd_len, .cmd_stop_mid, .wr_valid, .wr_data, .wr_ready,
    .rd_data, .rd_valid, .done, .nack_err);
  icrs_device icrs_device_inst (.reference_clock_input, .arst_n, .link(link_a.dev),
    .cfg_from_port, .hub_attach, .cfg_locked);
  // Second slave on its own link, driven bit by bit with a foreign address and then its own address.
  icrs_device icrs_device_inst_b (.reference_clock_input, .arst_n, .link(link_b.dev),
    .cfg_from_port(1'b0), .hub_attach(), .cfg_locked());
  icrs_link_sva icrs_link_sva_inst (.clk, .reference_clock_input, .arst_n,
    .scl(link_a.scl), .sda(link_a.sda), .host_scl_oe(link_a.host_scl_oe),
    .dev_sda_out(link_a.dev_sda_out), .dev_sda_oe(link_a.dev_sda_oe), .hub_attach, .cfg_locked);
  // ====================
  // Clocks and limit
  initial clk = 1'b0;
  always #20 clk = ~clk;
  initial
  begin
    reference_clock_input = 1'b0;
    #1.3;
    forever #3 reference_clock_input = ~reference_clock_input;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      chk("cycle limit", 8'h00, 8'h01);
      end_sim();
    end
  end
  // ====================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return (a == `ICRS_STCD_ADDR) ? {7'h00, lock} : mem[a];
  endfunction : exp_rd
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    lock = 1'b0;
    foreach (mem[i]) mem[i] = `ICRS_DEF_FILL;
    repeat (50) @(posedge clk);
  endtask : do_reset
  task automatic xfer(input logic rd, input logic [7:0] ra, input int n, input logic mid);
    int widx;
    int ridx;
    logic hs;
    logic dn;
    logic rv;
    logic [7:0] rdv;
    widx = 0;
    ridx = 0;
    dn = 1'b0;
    @(negedge clk);
    chk("command ready", 8'h01, {7'h00, cmd_ready});
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= ra;
    cmd_len <= n[7:0];
    cmd_stop_mid <= mid;
    wr_valid <= !rd;
    wr_data <= wbuf[0];
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (int t = 0; t < 30000 && !dn; t++)
    begin
      @(negedge clk);
      if (t == 0)
        chk("busy ready", 8'h00, {7'h00, cmd_ready});
      hs = wr_valid && wr_ready;
      dn = done;
      rv = rd_valid;
      rdv = rd_data;
      @(posedge clk);
      if (hs)
      begin
        widx++;
        wr_data <= wbuf[widx[3:0]];
      end
      if (rv)
      begin
        rbuf[ridx[3:0]] = rdv;
        ridx++;
      end
    end
    wr_valid <= 1'b0;
    chk("byte count", n[7:0], rd ? ridx[7:0] : widx[7:0]);
    chk("transfer done", 8'h01, {7'h00, dn});
    chk("slave refusal", 8'h00, {7'h00, nack_err});
  endtask : xfer
  task automatic wr(input logic [7:0] ra, input int n);
    logic [7:0] a;
    xfer(1'b0, ra, n, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      a = ra + i[7:0];
      if (a == `ICRS_STCD_ADDR)
        lock = lock | wbuf[i][`ICRS_WP_BIT];
      else if (!lock)
        mem[a] = wbuf[i];
    end
  endtask : wr
  task automatic rd(input logic [7:0] ra, input int n, input logic mid);
    xfer(1'b1, ra, n, mid);
    for (int i = 0; i < n; i++)
      chk("read byte", exp_rd(ra + i[7:0]), rbuf[i]);
  endtask : rd
  task automatic bb(input logic scl_lo, input logic sda_lo);
    link_b.host_scl_oe <= scl_lo;
    link_b.host_sda_oe <= sda_lo;
    repeat (8) @(posedge clk);
  endtask : bb
  task automatic bb_byte(input logic [7:0] b, input logic sda_exp);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      bb(1'b1, !b[i]);
      bb(1'b0, !b[i]);
      bb(1'b1, !b[i]);
    end
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    seen = link_b.sda;
    bb(1'b1, 1'b0);
    chk("ack slot level", {7'h00, sda_exp}, {7'h00, seen});
  endtask : bb_byte
  // ====================
  // Main sequence
  initial
  begin
    logic [7:0] ra;
    arst_n = 1'b0;
    cfg_from_port = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 8'h00;
    cmd_len = 8'h00;
    cmd_stop_mid = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    link_b.host_scl_out = 1'b0;
    link_b.host_sda_out = 1'b0;
    link_b.host_scl_oe = 1'b0;
    link_b.host_sda_oe = 1'b0;
    seed = 32'h3bc5;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    do_reset();
    chk("attach", 8'h00, {7'h00, hub_attach});
    chk("lock", 8'h00, {7'h00, cfg_locked});
    rd(8'h10, 4, 1'b0);
    $display("test defaults done");
    for (int k = 0; k < 6; k++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        seed = lfsr(lfsr(lfsr(seed)));
        wbuf[i] = seed[7:0];
      end
      seed = lfsr(seed);
      ra = {1'b0, seed[6:0]};
      wr(ra, 1 + int'(seed[9:8]));
      rd(ra, 2 + int'(seed[9:8]), k[0]);
    end
    $display("test random write and read done");
    wbuf[0] = 8'h01;
    wr(`ICRS_STCD_ADDR, 1);
    chk("lock", 8'h01, {7'h00, cfg_locked});
    chk("attach", 8'h01, {7'h00, hub_attach});
    wbuf[0] = 8'h00;
    wbuf[1] = 8'ha5;
    wr(`ICRS_STCD_ADDR, 2);
    rd(`ICRS_STCD_ADDR, 3, 1'b1);
    chk("lock", 8'h01, {7'h00, cfg_locked});
    $display("test write protect done");
    cfg_from_port <= 1'b0;
    do_reset();
    chk("lock", 8'h00, {7'h00, cfg_locked});
    chk("attach", 8'h01, {7'h00, hub_attach});
    rd(8'hfe, 4, 1'b0);
    $display("test default attach done");
    bb(1'b0, 1'b0);
    bb(1'b0, 1'b1);
    bb_byte(8'h12, 1'b1);
    bb_byte({`ICRS_SLAVE_ADDR, 1'b0}, 1'b1);
    bb(1'b0, 1'b0);
    bb(1'b0, 1'b1);
    bb_byte({`ICRS_SLAVE_ADDR, 1'b0}, 1'b0);
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    $display("test slave address done");
    end_sim();
  end
endmodule : i2c_config_register_slave_tb

// *** tb/icrs_link_sva.sv ***
// Concurrent checks on the two-wire configuration link and the slave's attach outputs.
`timescale 1ns/1ps
`include "icrs_params.svh"
module icrs_link_sva
  import icrs_pkg::*;
(
  input wire logic clk,                   // Master clock.
  input wire logic reference_clock_input, // Slave clock.
  input wire logic arst_n,                // Reset, active low.
  input wire logic scl,                   // Resolved clock line.
  input wire logic sda,                   // Resolved data line.
  input wire logic host_scl_oe,           // Master pulls clock low.
  input wire logic dev_sda_out,           // Slave data value.
  input wire logic dev_sda_oe,            // Slave pulls data low.
  input wire logic hub_attach,            // Upstream connect permitted.
  input wire logic cfg_locked             // Write protection active.
);
  // ====================
  // Helper logic
  logic [8:0] ld_cnt_reg;
  logic [7:0] hi_cnt_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic       first_reg;
  logic [3:0] nbit_reg;
  logic [7:0] sh_reg;
  logic       ack_slot;
  // Ninth clock rise after a start: the acknowledge slot of the address byte.
  assign ack_slot = scl && !scl_q_reg && first_reg && (nbit_reg == 4'h8);
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
      ld_cnt_reg <= 9'h000;
    else if (ld_cnt_reg != 9'h1ff)
      ld_cnt_reg <= ld_cnt_reg + 9'h001;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      hi_cnt_reg <= 8'h00;
    else if (host_scl_oe)
      hi_cnt_reg <= 8'h00;
    else if (hi_cnt_reg != 8'hff)
      hi_cnt_reg <= hi_cnt_reg + 8'h01;
  always_ff @(posedge reference_clock_input or negedge arst_n)
    if (!arst_n)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      first_reg <= 1'b0;
      nbit_reg  <= 4'h0;
      sh_reg    <= 8'h00;
    end
    else
    begin
      scl_q_reg <= scl;
      sda_q_reg <= sda;
      if (scl && scl_q_reg && (sda_q_reg != sda))
      begin
        first_reg <= !sda;
        nbit_reg  <= 4'h0;
      end
      else if (scl && !scl_q_reg)
      begin
        nbit_reg <= (nbit_reg == 4'h8) ? 4'h0 : nbit_reg + 4'h1;
        sh_reg   <= {sh_reg[6:0], sda};
        if (nbit_reg == 4'h8)
          first_reg <= 1'b0;
      end
    end
  // ====================
  // Assertions
  a_lock_once:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      cfg_locked |=> cfg_locked) else $error("Write protect cleared without reset.");
  a_attach_sticky:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      hub_attach |=> hub_attach) else $error("Attach dropped without reset.");
  a_no_early_attach:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      ld_cnt_reg < 9'h0fa |-> !hub_attach) else $error("Attach before defaults loaded.");
  a_lock_gives_attach:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      $rose(cfg_locked) |-> ##[0:4] hub_attach) else $error("No attach after config load.");
  a_open_drain_sda:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      dev_sda_oe |-> !dev_sda_out) else $error("Slave drives data line high.");
  a_sda_scl_low:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      $changed(dev_sda_oe) |-> !scl) else $error("Slave changed data while clock high.");
  a_scl_high_time:
    assert property (@(posedge clk) disable iff (!arst_n)
      $rose(host_scl_oe) |-> hi_cnt_reg >= 8'h0f) else $error("Clock high period too short.");
  a_ack_own_addr:
    assert property (@(posedge reference_clock_input) disable iff (!arst_n)
      ack_slot && (sh_reg[7:1] == `ICRS_SLAVE_ADDR) && (ld_cnt_reg == 9'h1ff) |-> !sda)
      else $error("Own address not acknowledged.");
  c_ack_seen: cover property (@(posedge reference_clock_input) disable iff (!arst_n)
    ack_slot && !sda);
  c_lock_set: cover property (@(posedge reference_clock_input) disable iff (!arst_n)
    $rose(cfg_locked));
  c_attach: cover property (@(posedge reference_clock_input) disable iff (!arst_n)
    $rose(hub_attach));
endmodule : icrs_link_sva
